// ### dv/iop_host.sv
`timescale 1ns/1ps
module iop_host (
  input  wire logic       clock_i,
  output logic      [7:0] addr_o  = 8'h00,
  output logic      [7:0] wdata_o = 8'h00,
  output logic            wr_o    = 1'b0,
  output logic            rd_o    = 1'b0,
  input  wire logic [7:0] rdata_i
);
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clock_i);
    wr_o    <= 1'b0;
    // released data never keeps its last value
    wdata_o <= ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clock_i);
    rd_o   <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule

// ### dv/iop_regs_asserts.sv
`timescale 1ns/1ps
module iop_regs_chk (
  input wire logic       clock_i, rst_i, wr_i, rd_i,
  input wire logic [7:0] addr_i, wdata_i, rdata_o, acc_off_y_o,
  input wire logic [9:0] gyr_off_z_o,
  input wire logic       gyr_off_en_o, adv_power_save_o, fifo_self_wake_o, fast_power_up_o,
  input wire logic       aux_en_o, gyr_en_o, acc_en_o, temp_en_o,
  input wire logic       gyro_trigger_o, fifo_flush_o, soft_reset_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire cw = wr_i && addr_i == 8'h7E;
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not idle");
  a_cmd_reads_zero: assert property ($past(rd_i) && $past(addr_i) == 8'h7E |-> rdata_o == 8'h00)
    else $error("command register read not zero");
  a_acc_y_write: assert property (wr_i && addr_i == 8'h72 |-> ##2 acc_off_y_o == $past(wdata_i, 2))
    else $error("accel y offset not written");
  a_gyr_high_bits: assert property (wr_i && addr_i == 8'h77 |-> ##2
    {gyr_off_en_o, gyr_off_z_o[9:8]} == $past(wdata_i[6:4], 2)) else $error("gyro high bits wrong");
  a_pwr_cfg_bits: assert property (wr_i && addr_i == 8'h7C |-> ##2
    {fast_power_up_o, fifo_self_wake_o, adv_power_save_o} == $past(wdata_i[2:0], 2))
    else $error("power configuration outputs wrong");
  a_pwr_ctl_bits: assert property (wr_i && addr_i == 8'h7D |-> ##2
    {temp_en_o, acc_en_o, gyr_en_o, aux_en_o} == $past(wdata_i[3:0], 2))
    else $error("power control outputs wrong");
  a_trig_cause: assert property (gyro_trigger_o |-> $past(cw) && $past(wdata_i) == 8'h02)
    else $error("gyro trigger without its code");
  a_flush_pulse: assert property (cw && wdata_i == 8'hB0 |=> fifo_flush_o)
    else $error("flush code gave no pulse");
  a_soft_defaults: assert property (soft_reset_o |=> adv_power_save_o && fifo_self_wake_o
    && acc_off_y_o == 8'h00 && !aux_en_o) else $error("soft reset left settings");
  c_soft: cover property (cw && wdata_i == 8'hB6);
  c_gyr_hi: cover property (wr_i && addr_i == 8'h77);
  c_cfg_rd: cover property (rd_i && addr_i == 8'h7C);
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic clock_i = 1'b0;
  logic rst_i   = 1'b1;
  logic [7:0] addr_i, wdata_i, rdata_o, acc_off_y_o, acc_off_z_o, d;
  logic [9:0] gyr_off_x_o, gyr_off_y_o, gyr_off_z_o;
  logic wr_i, rd_i, gyr_off_en_o, gyr_gain_en_o, adv_power_save_o, fifo_self_wake_o;
  logic fast_power_up_o, aux_en_o, gyr_en_o, acc_en_o, temp_en_o, gyro_trigger_o;
  logic gain_apply_o, nvm_program_o, fifo_flush_o, soft_reset_o;
  int mismatches = 0;
  int checks = 0;
  logic [7:0] ra[8] = '{8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h7C, 8'h7D};
  logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
  logic [7:0] wv[8] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h81, 8'hE4, 8'h04, 8'h0A};
  logic [7:0] cd[5] = '{8'h02, 8'h03, 8'hA0, 8'hB0, 8'hB6};
  always #20 clock_i = ~clock_i;
  iop_regs i_dut (.*);
  iop_host i_host (.clock_i(clock_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
                   .rd_o(rd_i), .rdata_i(rdata_o));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic t_defaults();
    for (int i = 0; i < 8; i++) begin
      i_host.read(ra[i], d);
      chk("default", d, rv[i]);
    end
    i_host.read(8'h71, d);
    chk("unmapped", d, 16'h0000);
    $display("defaults test done");
  endtask
  task automatic t_regs();
    for (int i = 0; i < 8; i++) i_host.write(ra[i], wv[i]);
    for (int i = 0; i < 8; i++) begin
      i_host.read(ra[i], d);
      chk("readback", d, wv[i]);
    end
    chk("accel y", acc_off_y_o, 16'h00A5);
    chk("accel z", acc_off_z_o, 16'h005A);
    chk("gyro x", gyr_off_x_o, 16'h003C);
    chk("gyro y", gyr_off_y_o, 16'h01C3);
    chk("gyro z", gyr_off_z_o, 16'h0281);
    chk("enables", {gyr_gain_en_o, gyr_off_en_o, fast_power_up_o, fifo_self_wake_o,
        adv_power_save_o, temp_en_o, acc_en_o, gyr_en_o, aux_en_o}, 16'h01CA);
    $display("register test done");
  endtask
  task automatic t_cmds();
    i_host.write(8'h7E, 8'h55);
    #1 chk("unknown code", {gyro_trigger_o, gain_apply_o, nvm_program_o, fifo_flush_o,
        soft_reset_o}, 16'h0000);
    i_host.read(8'h7E, d);
    chk("command read", d, 16'h0000);
    i_host.read(8'h7D, d);
    chk("kept after unknown", d, 16'h000A);
    for (int i = 0; i < 5; i++) begin
      i_host.write(8'h7E, cd[i]);
      #1 chk("pulse", {gyro_trigger_o, gain_apply_o, nvm_program_o, fifo_flush_o,
          soft_reset_o}, 16'h0010 >> i);
    end
    for (int i = 0; i < 8; i++) begin
      i_host.read(ra[i], d);
      chk("after soft reset", d, rv[i]);
    end
    chk("levels after soft reset", {gyr_gain_en_o, gyr_off_en_o, fast_power_up_o,
        fifo_self_wake_o, adv_power_save_o, temp_en_o, acc_en_o, gyr_en_o, aux_en_o},
        16'h0030);
    chk("gyro z after soft reset", gyr_off_z_o, 16'h0000);
    $display("command test done");
  endtask
  task automatic t_mid_reset();
    i_host.write(8'h72, 8'h11);
    i_host.write(8'h7C, 8'h04);
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    i_host.read(8'h72, d);
    chk("accel y after reset", d, 16'h0000);
    i_host.read(8'h7C, d);
    chk("power config after reset", d, 16'h0003);
    chk("power levels after reset", {fast_power_up_o, fifo_self_wake_o, adv_power_save_o},
        16'h0003);
    $display("mid-run reset test done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    t_defaults();
    t_regs();
    t_cmds();
    t_mid_reset();
    print_verdict();
  end
endmodule
bind iop_regs iop_regs_chk i_chk (.*);

// ### logic/iop_pkg.sv
package iop_pkg;
  // register addresses
  localparam logic [7:0] ADDR_ACC_OFF_Y   = 8'h72;
  localparam logic [7:0] ADDR_ACC_OFF_Z   = 8'h73;
  localparam logic [7:0] ADDR_GYR_OFF_X   = 8'h74;
  localparam logic [7:0] ADDR_GYR_OFF_Y   = 8'h75;
  localparam logic [7:0] ADDR_GYR_OFF_Z   = 8'h76;
  localparam logic [7:0] ADDR_GYR_OFF_HI  = 8'h77;
  localparam logic [7:0] ADDR_PWR_CONFIG  = 8'h7C;
  localparam logic [7:0] ADDR_PWR_CONTROL = 8'h7D;
  localparam logic [7:0] ADDR_COMMAND     = 8'h7E;

  // reset values
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_PWR_CONFIG = 8'h03;
  localparam logic [7:0] READ_ZERO      = 8'h00;

  // field positions in the shared gyro register
  localparam int GYR_HI_X_LSB  = 0;
  localparam int GYR_HI_Y_LSB  = 2;
  localparam int GYR_HI_Z_LSB  = 4;
  localparam int GYR_OFF_EN_BIT  = 6;
  localparam int GYR_GAIN_EN_BIT = 7;

  // power configuration fields
  localparam int PWR_APS_BIT  = 0;
  localparam int PWR_FSW_BIT  = 1;
  localparam int PWR_FUP_BIT  = 2;

  // power control fields
  localparam int PCTL_AUX_BIT  = 0;
  localparam int PCTL_GYR_BIT  = 1;
  localparam int PCTL_ACC_BIT  = 2;
  localparam int PCTL_TEMP_BIT = 3;

  // command codes
  localparam logic [7:0] CMD_GYRO_TRIGGER = 8'h02;
  localparam logic [7:0] CMD_GAIN_APPLY   = 8'h03;
  localparam logic [7:0] CMD_NVM_PROGRAM  = 8'hA0;
  localparam logic [7:0] CMD_FIFO_FLUSH   = 8'hB0;
  localparam logic [7:0] CMD_SOFT_RESET   = 8'hB6;
endpackage

// ### logic/iop_regs.sv
// Notes on behaviour
// - accel Y and Z offsets, 8-bit read/write
// - gyro offsets are 10 bits, shared high bits
// - offset enable adds gyro offsets to data
// - gain enable applies gyro gain compensation
// - offset registers reset to zero
// - power config resets 0x03, bit0 power save
// - bit1 allows FIFO reads in low power
// - bit2 enables fast power up
// - power control bits enable four subsystems
// - command register always reads zero
// - code 0x02 triggers gyro operations
// - code 0x03 applies new gyro gain
// - 0xa0 programs NVM, 0xb0 flushes FIFO
// - 0xb6 soft reset restores all defaults
`timescale 1ns/1ps
module iop_regs #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // offsets to the datapaths
  output logic      [7:0]        acc_off_y_o,
  output logic      [7:0]        acc_off_z_o,
  output logic      [9:0]        gyr_off_x_o,
  output logic      [9:0]        gyr_off_y_o,
  output logic      [9:0]        gyr_off_z_o,
  output logic                   gyr_off_en_o,
  output logic                   gyr_gain_en_o,
  // power controls
  output logic                   adv_power_save_o,
  output logic                   fifo_self_wake_o,
  output logic                   fast_power_up_o,
  output logic                   aux_en_o,
  output logic                   gyr_en_o,
  output logic                   acc_en_o,
  output logic                   temp_en_o,
  // command pulses
  output logic                   gyro_trigger_o,
  output logic                   gain_apply_o,
  output logic                   nvm_program_o,
  output logic                   fifo_flush_o,
  output logic                   soft_reset_o
);

  logic [7:0] acc_off_y;
  logic [7:0] acc_off_z;
  logic [7:0] gyr_lo_x;
  logic [7:0] gyr_lo_y;
  logic [7:0] gyr_lo_z;
  logic [7:0] gyr_hi;
  logic [7:0] pwr_cfg;
  logic [7:0] pwr_ctl;
  logic       wr_cmd;
  logic       soft_rst;
  logic       clr;
  logic [7:0] next_rdata;

  assign wr_cmd = wr_i && (addr_i[7:0] == iop_pkg::ADDR_COMMAND);
  // soft reset is decoded combinationally so the defaults land on the same edge
  assign soft_rst = wr_cmd && (wdata_i[7:0] == iop_pkg::CMD_SOFT_RESET);
  assign clr = rst_i || soft_rst;

  // offset registers
  always_ff @(posedge clock_i) begin
    if (clr) begin
      acc_off_y <= iop_pkg::RST_ZERO;
      acc_off_z <= iop_pkg::RST_ZERO;
      gyr_lo_x  <= iop_pkg::RST_ZERO;
      gyr_lo_y  <= iop_pkg::RST_ZERO;
      gyr_lo_z  <= iop_pkg::RST_ZERO;
      gyr_hi    <= iop_pkg::RST_ZERO;
    end else if (wr_i) begin
      unique case (addr_i[7:0])
        iop_pkg::ADDR_ACC_OFF_Y:  acc_off_y <= wdata_i[7:0];
        iop_pkg::ADDR_ACC_OFF_Z:  acc_off_z <= wdata_i[7:0];
        iop_pkg::ADDR_GYR_OFF_X:  gyr_lo_x  <= wdata_i[7:0];
        iop_pkg::ADDR_GYR_OFF_Y:  gyr_lo_y  <= wdata_i[7:0];
        iop_pkg::ADDR_GYR_OFF_Z:  gyr_lo_z  <= wdata_i[7:0];
        iop_pkg::ADDR_GYR_OFF_HI: gyr_hi    <= wdata_i[7:0];
        default: ;
      endcase
    end
  end

  // power registers
  always_ff @(posedge clock_i) begin
    if (clr) begin
      pwr_cfg <= iop_pkg::RST_PWR_CONFIG;
      pwr_ctl <= iop_pkg::RST_ZERO;
    end else if (wr_i && addr_i[7:0] == iop_pkg::ADDR_PWR_CONFIG) begin
      pwr_cfg <= wdata_i[7:0];
    end else if (wr_i && addr_i[7:0] == iop_pkg::ADDR_PWR_CONTROL) begin
      pwr_ctl <= wdata_i[7:0];
    end
  end

  // outputs to the datapaths, registered
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      acc_off_y_o      <= iop_pkg::RST_ZERO;
      acc_off_z_o      <= iop_pkg::RST_ZERO;
      gyr_off_x_o      <= '0;
      gyr_off_y_o      <= '0;
      gyr_off_z_o      <= '0;
      gyr_off_en_o     <= 1'b0;
      gyr_gain_en_o    <= 1'b0;
      // follow the power register's own reset so no false low leaks out of reset
      adv_power_save_o <= iop_pkg::RST_PWR_CONFIG[iop_pkg::PWR_APS_BIT];
      fifo_self_wake_o <= iop_pkg::RST_PWR_CONFIG[iop_pkg::PWR_FSW_BIT];
      fast_power_up_o  <= iop_pkg::RST_PWR_CONFIG[iop_pkg::PWR_FUP_BIT];
      aux_en_o         <= 1'b0;
      gyr_en_o         <= 1'b0;
      acc_en_o         <= 1'b0;
      temp_en_o        <= 1'b0;
    end else begin
      acc_off_y_o      <= acc_off_y;
      acc_off_z_o      <= acc_off_z;
      gyr_off_x_o      <= {gyr_hi[iop_pkg::GYR_HI_X_LSB +: 2], gyr_lo_x};
      gyr_off_y_o      <= {gyr_hi[iop_pkg::GYR_HI_Y_LSB +: 2], gyr_lo_y};
      gyr_off_z_o      <= {gyr_hi[iop_pkg::GYR_HI_Z_LSB +: 2], gyr_lo_z};
      gyr_off_en_o     <= gyr_hi[iop_pkg::GYR_OFF_EN_BIT];
      gyr_gain_en_o    <= gyr_hi[iop_pkg::GYR_GAIN_EN_BIT];
      adv_power_save_o <= pwr_cfg[iop_pkg::PWR_APS_BIT];
      fifo_self_wake_o <= pwr_cfg[iop_pkg::PWR_FSW_BIT];
      fast_power_up_o  <= pwr_cfg[iop_pkg::PWR_FUP_BIT];
      aux_en_o         <= pwr_ctl[iop_pkg::PCTL_AUX_BIT];
      gyr_en_o         <= pwr_ctl[iop_pkg::PCTL_GYR_BIT];
      acc_en_o         <= pwr_ctl[iop_pkg::PCTL_ACC_BIT];
      temp_en_o        <= pwr_ctl[iop_pkg::PCTL_TEMP_BIT];
    end
  end

  // command pulses, one cycle after the write; other codes do nothing
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gyro_trigger_o <= 1'b0;
      gain_apply_o   <= 1'b0;
      nvm_program_o  <= 1'b0;
      fifo_flush_o   <= 1'b0;
      soft_reset_o   <= 1'b0;
    end else begin
      gyro_trigger_o <= wr_cmd && wdata_i[7:0] == iop_pkg::CMD_GYRO_TRIGGER;
      gain_apply_o   <= wr_cmd && wdata_i[7:0] == iop_pkg::CMD_GAIN_APPLY;
      nvm_program_o  <= wr_cmd && wdata_i[7:0] == iop_pkg::CMD_NVM_PROGRAM;
      fifo_flush_o   <= wr_cmd && wdata_i[7:0] == iop_pkg::CMD_FIFO_FLUSH;
      soft_reset_o   <= soft_rst;
    end
  end

  // read mux; command and unmapped addresses read zero
  always_comb begin
    next_rdata = iop_pkg::READ_ZERO;
    unique case (addr_i[7:0])
      iop_pkg::ADDR_ACC_OFF_Y:   next_rdata = acc_off_y;
      iop_pkg::ADDR_ACC_OFF_Z:   next_rdata = acc_off_z;
      iop_pkg::ADDR_GYR_OFF_X:   next_rdata = gyr_lo_x;
      iop_pkg::ADDR_GYR_OFF_Y:   next_rdata = gyr_lo_y;
      iop_pkg::ADDR_GYR_OFF_Z:   next_rdata = gyr_lo_z;
      iop_pkg::ADDR_GYR_OFF_HI:  next_rdata = gyr_hi;
      iop_pkg::ADDR_PWR_CONFIG:  next_rdata = pwr_cfg;
      iop_pkg::ADDR_PWR_CONTROL: next_rdata = pwr_ctl;
      default: ;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= DATA_W'(next_rdata);
    end else begin
      rdata_o <= '0;
    end
  end

endmodule
